// >>> rtl/seize_pkg.sv
// Purpose: Shared constants for the dual-port drive seize logic.
// Assumes: 250 MHz controller clock, 16-bit emulated drive registers.
// Notes: Register indices sit in the low address bits, drive number above.
package seize_pkg;
  // Clock and time figures.
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned ONE_SEC_NS = 1000000000;
  localparam int unsigned SEC_CYCLES = ONE_SEC_NS / CLK_PERIOD_NS;
  localparam int unsigned RELEASE_NS = 5000;
  localparam int unsigned RELEASE_CYCLES = RELEASE_NS / CLK_PERIOD_NS;

  // Register bus geometry.
  localparam int unsigned REG_SEL_W = 3;
  localparam int unsigned DATA_W = 16;

  // Register indices within a drive window.
  localparam logic [2:0] REG_CTL = 3'h0;
  localparam logic [2:0] REG_STAT = 3'h1;
  localparam logic [2:0] REG_ATTN = 3'h2;
  localparam logic [2:0] REG_TYPE = 3'h3;
  localparam logic [2:0] REG_GEN = 3'h4;

  // Drive control register fields.
  localparam int unsigned CTL_GO = 0;
  localparam int unsigned CTL_FN_LO = 1;
  localparam int unsigned CTL_FN_HI = 5;
  localparam int unsigned CTL_IE = 6;
  localparam int unsigned CTL_DVA = 11;

  // Drive status and type register fields.
  localparam int unsigned STAT_ATA = 15;
  localparam int unsigned STAT_PGM = 9;
  localparam int unsigned STAT_DRY = 7;
  localparam int unsigned TYPE_DPM = 11;
  localparam int unsigned TYPE_CODE_HI = 7;

  // Function code that hands the drive back to the other port.
  localparam logic [4:0] FUNC_RELEASE = 5'h05;

  // Switch bit positions in the synchronised switch vector.
  localparam int unsigned SW_DPORT = 0;
  localparam int unsigned SW_DACC = 1;
endpackage

// >>> rtl/dual_port_drive_seize_logic.sv
// Purpose: Seize, release and request logic for drives shared by two ports.
// Assumes: Peer busy and drive present arrive from drive pins; the data
//          transfer flag comes from logic on the same clock.
// Notes: Operation
// Operation
// - Any host write to a drive register requests seizing that drive.
// - Writing one to a drive's attention bit also requests a seize.
// - On connection the drive-available flag, control bit 11, is set.
// - Peer-held drive: available clear, reads zero, writes have no effect.
// - Seize request while peer busy is latched, carried out after release.
// - A release function to a seized drive returns it to unseized.
// - One second without seize-type access releases the seized drive.
// - Control register read restarts the release timer when seized here.
// - Freed drive with request flag is seized and its attention set.
// - Unserviced deferred seize releases after one second, attention stays.
// - Not yet seized drive reads as peer-held; host waits for attention.
// - During the release delay the drive already shows as unseized.
// - Data transfer suspends timers and any poll, seize or release; here it holds only the release timer and seizes.
// - Single-port mode: drive always seized, no attention on peer free.
// - Single-port mode: command waits, untimed, while peer holds drive.
// - Dual-access switch sets dual-port and programmable indications.
// - Dual-access: command to busy drive waits, then seizes and executes; here it waits for the peer to free the drive and issues without seizing.
// - Each drive is ignored one second when first seen; dual-access skips.
// - Dual-port switch overrides dual-access, except the stall bypass.
// - Control read: zeros unless seized here, then available and timer reset.
// - Control write: request plus attempt when unseized, else load function.
// - Other writes: discarded with request when unseized, loaded when seized.
// - Seize and release behaviour only with the dual-port switch on.
// - Attention interrupt stays until the host clears the attention bits.
//
// The register offsets and the strobed register port were left to the implementer.
module dual_port_drive_seize_logic #(
  parameter int unsigned NUM_DRIVES = 4,
  parameter int unsigned DRV_W = 2,
  parameter int unsigned SEC_CYC = seize_pkg::SEC_CYCLES,
  parameter int unsigned REL_CYC = seize_pkg::RELEASE_CYCLES,
  parameter logic [7:0] TYPE_CODE = 8'h24
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [DRV_W+seize_pkg::REG_SEL_W-1:0] i_addr,
  input wire logic [seize_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [seize_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_xfer_busy,
  input wire logic [NUM_DRIVES-1:0] i_peer_busy,
  input wire logic [NUM_DRIVES-1:0] i_drive_present,
  input wire logic i_dual_port_switch,
  input wire logic i_dual_access_switch,
  output logic [NUM_DRIVES-1:0] o_port_hold,
  output logic o_cmd_valid,
  output logic [DRV_W-1:0] o_cmd_drive,
  output logic [4:0] o_cmd_func,
  output logic o_irq
);
  import seize_pkg::*;

  localparam int unsigned CW = $clog2(SEC_CYC + 1);
  localparam int unsigned RW = $clog2(REL_CYC + 1);
  localparam logic [CW-1:0] SEC_LAST = CW'(SEC_CYC - 1);
  localparam logic [RW-1:0] REL_LAST = RW'(REL_CYC - 1);

  typedef struct packed {
    logic [NUM_DRIVES-1:0] peer_s1;
    logic [NUM_DRIVES-1:0] peer_s2;
    logic [NUM_DRIVES-1:0] pres_s1;
    logic [NUM_DRIVES-1:0] pres_s2;
    logic [1:0] sw_s1;
    logic [1:0] sw_s2;
    logic [NUM_DRIVES-1:0] seized;
    logic [NUM_DRIVES-1:0] req;
    logic [NUM_DRIVES-1:0] attn;
    logic [NUM_DRIVES-1:0] seen;
    logic [NUM_DRIVES-1:0] stall;
    logic [NUM_DRIVES-1:0] pend;
    logic [NUM_DRIVES-1:0] rel;
    logic [NUM_DRIVES-1:0][CW-1:0] cnt;
    logic [NUM_DRIVES-1:0][RW-1:0] rcnt;
    logic [NUM_DRIVES-1:0][4:0] func;
    logic [NUM_DRIVES-1:0][DATA_W-1:0] gen;
    logic ie;
    logic [DATA_W-1:0] rdata;
    logic cmd_v;
    logic [DRV_W-1:0] cmd_drv;
    logic [4:0] cmd_fn;
    logic irq;
  } st_t;

  st_t r;
  st_t n;

  logic [DRV_W-1:0] a_drv;
  logic [2:0] a_reg;
  logic dp_mode;
  logic da_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Address split and operating mode from the synchronised switches.
  assign a_drv = i_addr[DRV_W+REG_SEL_W-1:REG_SEL_W];
  assign a_reg = i_addr[REG_SEL_W-1:0];
  assign dp_mode = r.sw_s2[SW_DPORT];
  assign da_mode = r.sw_s2[SW_DACC] & ~r.sw_s2[SW_DPORT];

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for every drive and the registered read port.
  always_comb begin
    logic hit;
    logic atw;
    logic ctl_wr;
    logic rd_ctl;
    logic free;
    logic local_ok;
    logic issued;
    logic go_wr;
    logic [DATA_W-1:0] rv;
    hit = 1'b0;
    atw = 1'b0;
    ctl_wr = 1'b0;
    rd_ctl = 1'b0;
    free = 1'b0;
    local_ok = 1'b0;
    issued = 1'b0;
    go_wr = 1'b0;
    rv = '0;
    n = r;
    // Pins pass two flip-flops before any logic reads them.
    n.peer_s1 = i_peer_busy;
    n.peer_s2 = r.peer_s1;
    n.pres_s1 = i_drive_present;
    n.pres_s2 = r.pres_s1;
    n.sw_s1 = {i_dual_access_switch, i_dual_port_switch};
    n.sw_s2 = r.sw_s1;
    n.cmd_v = 1'b0;
    for (int d = 0; d < NUM_DRIVES; d++) begin
      hit = i_wr && (a_drv == DRV_W'(d)) && (a_reg != REG_ATTN);
      atw = i_wr && (a_reg == REG_ATTN) && i_wdata[d];
      ctl_wr = hit && (a_reg == REG_CTL);
      // A go written in the issuing cycle keeps the command pending.
      go_wr = ctl_wr && i_wdata[CTL_GO]
              && (i_wdata[CTL_FN_HI:CTL_FN_LO] != FUNC_RELEASE);
      rd_ctl = i_rd && (a_drv == DRV_W'(d)) && (a_reg == REG_CTL);
      free = ~r.peer_s2[d] & ~i_xfer_busy & ~r.stall[d] & ~r.rel[d];
      local_ok = r.seized[d] & ~r.rel[d];
      // Writing one clears attention; a new attention in the same cycle wins.
      if (atw) begin
        n.attn[d] = 1'b0;
      end
      // First sight of a drive starts the stall unless dual access is set.
      if (r.pres_s2[d] && !r.seen[d]) begin
        n.seen[d] = 1'b1;
        n.stall[d] = ~r.sw_s2[SW_DACC];
        n.cnt[d] = '0;
      end else if (r.stall[d]) begin
        if (r.cnt[d] == SEC_LAST) begin
          n.stall[d] = 1'b0;
          n.cnt[d] = '0;
        end else begin
          n.cnt[d] = r.cnt[d] + 1'b1;
        end
      end
      if (dp_mode) begin
        if (local_ok) begin
          // Seize-type accesses and control reads refresh the timer.
          if (hit || atw || rd_ctl) begin
            n.cnt[d] = '0;
          end else if (!i_xfer_busy) begin
            if (r.cnt[d] == SEC_LAST) begin
              n.rel[d] = 1'b1;
              n.rcnt[d] = '0;
              n.cnt[d] = '0;
            end else begin
              n.cnt[d] = r.cnt[d] + 1'b1;
            end
          end
          if (ctl_wr) begin
            n.func[d] = i_wdata[CTL_FN_HI:CTL_FN_LO];
            n.ie = i_wdata[CTL_IE];
            if (i_wdata[CTL_GO]
                && i_wdata[CTL_FN_HI:CTL_FN_LO] == FUNC_RELEASE) begin
              n.rel[d] = 1'b1;
              n.rcnt[d] = '0;
            end else if (i_wdata[CTL_GO]) begin
              n.pend[d] = 1'b1;
            end
          end
          if (hit && a_reg == REG_GEN) begin
            n.gen[d] = i_wdata;
          end
        end else if (!r.seized[d]) begin
          // Writes to an unseized or peer-held drive leave a request; a control go also stores its function as pending.
          if (hit || atw) begin
            n.req[d] = 1'b1;
          end
          if (ctl_wr && i_wdata[CTL_GO]) begin
            n.func[d] = i_wdata[CTL_FN_HI:CTL_FN_LO];
            n.pend[d] = 1'b1;
          end
          // A requested drive that is free is taken and attention is raised.
          if ((r.req[d] || hit || atw) && free) begin
            n.seized[d] = 1'b1;
            n.attn[d] = 1'b1;
            n.req[d] = 1'b0;
            n.cnt[d] = '0;
          end
        end
        // The port is handed back only after the release delay.
        if (r.rel[d]) begin
          if (r.rcnt[d] == REL_LAST) begin
            n.rel[d] = 1'b0;
            n.seized[d] = 1'b0;
          end else begin
            n.rcnt[d] = r.rcnt[d] + 1'b1;
          end
        end
        if (r.pend[d] && local_ok && !issued) begin
          issued = 1'b1;
          n.pend[d] = go_wr;
          n.cmd_v = 1'b1;
          n.cmd_drv = DRV_W'(d);
          n.cmd_fn = r.func[d];
        end
      end else begin
        // Single port: no seize state, commands wait for the peer untimed.
        n.seized[d] = 1'b0;
        n.rel[d] = 1'b0;
        n.req[d] = 1'b0;
        if (ctl_wr && !r.stall[d]) begin
          n.func[d] = i_wdata[CTL_FN_HI:CTL_FN_LO];
          n.ie = i_wdata[CTL_IE];
          if (i_wdata[CTL_GO]
              && i_wdata[CTL_FN_HI:CTL_FN_LO] != FUNC_RELEASE) begin
            n.pend[d] = 1'b1;
          end
        end
        if (hit && a_reg == REG_GEN && !r.stall[d]) begin
          n.gen[d] = i_wdata;
        end
        if (r.pend[d] && !r.peer_s2[d] && !r.stall[d] && !issued) begin
          issued = 1'b1;
          n.pend[d] = go_wr;
          n.cmd_v = 1'b1;
          n.cmd_drv = DRV_W'(d);
          n.cmd_fn = r.func[d];
        end
      end
    end
    // Read port: drives not seized here (dual-port) or stalled (single-port) read as zero; the attention register always reads.
    local_ok = dp_mode ? (r.seized[a_drv] & ~r.rel[a_drv])
                       : ~r.stall[a_drv];
    unique case (a_reg)
      REG_CTL: begin
        rv[CTL_DVA] = 1'b1;
        rv[CTL_IE] = r.ie;
        rv[CTL_FN_HI:CTL_FN_LO] = r.func[a_drv];
        rv[CTL_GO] = r.pend[a_drv];
      end
      REG_STAT: begin
        rv[STAT_ATA] = r.attn[a_drv];
        rv[STAT_DRY] = ~r.pend[a_drv];
        rv[STAT_PGM] = da_mode;
      end
      REG_TYPE: begin
        rv[TYPE_DPM] = da_mode;
        rv[TYPE_CODE_HI:0] = TYPE_CODE;
      end
      REG_GEN: begin
        rv = r.gen[a_drv];
      end
      default: begin
        rv = '0;
      end
    endcase
    if (!i_rd) begin
      n.rdata = '0;
    end else if (a_reg == REG_ATTN) begin
      n.rdata = DATA_W'(r.attn);
    end else begin
      n.rdata = local_ok ? rv : '0;
    end
    n.irq = n.ie & (|n.attn);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register with synchronous clear.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops; the port hold is the OR of the seized and releasing flops.
  assign o_rdata = r.rdata;
  assign o_port_hold = r.seized | r.rel;
  assign o_cmd_valid = r.cmd_v;
  assign o_cmd_drive = r.cmd_drv;
  assign o_cmd_func = r.cmd_fn;
  assign o_irq = r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on single drives, on the read port and on the interrupt.
  property p_dva_read;
    @(posedge i_clk) disable iff (i_srst)
    (i_rd && a_reg == REG_CTL && dp_mode && r.seized[a_drv]
     && !r.rel[a_drv]) |=> o_rdata[CTL_DVA];
  endproperty
  a_dva_read: assert property (p_dva_read)
    else $error("Available flag missing on seized control read.");

  property p_peer_zero;
    @(posedge i_clk) disable iff (i_srst)
    (i_rd && a_reg != REG_ATTN && dp_mode && !r.seized[a_drv])
    |=> (o_rdata == '0);
  endproperty
  a_peer_zero: assert property (p_peer_zero)
    else $error("Unseized drive did not read as zero.");

  property p_req_latch;
    @(posedge i_clk) disable iff (i_srst)
    (i_wr && a_reg != REG_ATTN && dp_mode && !r.seized[a_drv]
     && r.peer_s2[a_drv]) |=> r.req[$past(a_drv)];
  endproperty
  a_req_latch: assert property (p_req_latch)
    else $error("Seize request to busy drive was not latched.");

  property p_release;
    @(posedge i_clk) disable iff (i_srst)
    (i_wr && a_drv == '0 && a_reg == REG_CTL && i_wdata[CTL_GO]
     && i_wdata[CTL_FN_HI:CTL_FN_LO] == FUNC_RELEASE && dp_mode
     && r.seized[0] && !r.rel[0]) |=> (r.rel[0] && o_port_hold[0]);
  endproperty
  a_release: assert property (p_release)
    else $error("Release write did not start the release.");

  property p_rel_zero;
    @(posedge i_clk) disable iff (i_srst)
    (i_rd && a_reg != REG_ATTN && dp_mode && r.rel[a_drv])
    |=> (o_rdata == '0);
  endproperty
  a_rel_zero: assert property (p_rel_zero)
    else $error("Drive being released did not read as zero.");

  property p_timeout;
    @(posedge i_clk) disable iff (i_srst)
    (dp_mode && r.seized[2] && !r.rel[2] && r.cnt[2] == SEC_LAST
     && !i_xfer_busy && !i_wr && !i_rd) |=> r.rel[2];
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("Release timer expiry did not start a release.");

  property p_read_refresh;
    @(posedge i_clk) disable iff (i_srst)
    (i_rd && a_drv == '0 && a_reg == REG_CTL && dp_mode
     && r.seized[0] && !r.rel[0]) |=> (r.cnt[0] == '0);
  endproperty
  a_read_refresh: assert property (p_read_refresh)
    else $error("Control read did not restart the timer.");

  property p_deferred;
    @(posedge i_clk) disable iff (i_srst)
    (dp_mode && !r.seized[1] && r.req[1] && !r.peer_s2[1]
     && !i_xfer_busy && !r.stall[1] && !r.rel[1])
    |=> (r.seized[1] && r.attn[1] && !r.req[1]);
  endproperty
  a_deferred: assert property (p_deferred)
    else $error("Freed requested drive was not seized with attention.");

  property p_xfer_hold;
    @(posedge i_clk) disable iff (i_srst)
    (dp_mode && i_xfer_busy && !r.rel[2] && r.seized[2] == 1'b0)
    |=> !r.seized[2];
  endproperty
  a_xfer_hold: assert property (p_xfer_hold)
    else $error("Drive seized during a data transfer.");

  property p_single_no_attn;
    @(posedge i_clk) disable iff (i_srst)
    !dp_mode ##1 !dp_mode |-> !$rose(r.attn[0]);
  endproperty
  a_single_no_attn: assert property (p_single_no_attn)
    else $error("Attention raised in single-port mode.");

  property p_irq_hold;
    @(posedge i_clk) disable iff (i_srst)
    (r.attn != '0 && r.ie && !(i_wr && a_reg == REG_ATTN)
     && !(i_wr && a_reg == REG_CTL)) |=> o_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("Interrupt dropped while attention still set.");
endmodule

// >>> test/peer_port_model.sv
// Purpose: Behavioural peer controller standing on the far drive ports.
// Assumes: One clock; the bench tells the peer which drives it wants.
// Notes: The peer only wins a drive that this side does not hold.
module peer_port_model #(
  parameter int unsigned NUM_DRIVES = 4
) (
  input wire logic i_clk,
  input wire logic [NUM_DRIVES-1:0] i_claim,
  input wire logic [NUM_DRIVES-1:0] i_port_hold,
  output logic [NUM_DRIVES-1:0] o_peer_busy,
  output logic [NUM_DRIVES-1:0] o_drive_present
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////
  // Every drive is powered and cabled for the whole run.
  assign o_drive_present = '1;

  // First come, first served: a claim only takes a drive left free here,
  // and dropping a claim hands the drive back at once.
  initial o_peer_busy = '0;
  always @(posedge i_clk) begin
    o_peer_busy <= i_claim & (o_peer_busy | ~i_port_hold);
  end
endmodule

// >>> test/dual_port_drive_seize_logic_bench.sv
// Purpose: Self-checking bench for the dual-port drive seize logic.
// Assumes: Shortened one-second and release counts set below.
// Notes: Dual-port mode first, then single-port mode and the first stall.
module dual_port_drive_seize_logic_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import seize_pkg::*;

  localparam int SEC = 50;
  localparam int REL = 8;

  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [4:0] i_addr = 5'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_xfer_busy = 1'b0;
  logic i_dual_port_switch = 1'b1;
  logic i_dual_access_switch = 1'b1;
  logic [3:0] claim = 4'h0;
  logic [3:0] peer_busy;
  logic [3:0] present;
  logic [15:0] o_rdata;
  logic [3:0] o_port_hold;
  logic o_cmd_valid;
  logic [1:0] o_cmd_drive;
  logic [4:0] o_cmd_func;
  logic o_irq;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  ////////////////////////////////////////////////////////////////////////
  // Clock at 4 ns and a cycle ceiling that cuts a hang short.
  always #2 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      $display("ERROR %0t cycle limit reached", $time);
      end_sim();
    end
  end

  dual_port_drive_seize_logic #(
    .SEC_CYC(SEC),
    .REL_CYC(REL)
  ) dut_u (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_xfer_busy(i_xfer_busy),
    .i_peer_busy(peer_busy),
    .i_drive_present(present),
    .i_dual_port_switch(i_dual_port_switch),
    .i_dual_access_switch(i_dual_access_switch),
    .o_port_hold(o_port_hold),
    .o_cmd_valid(o_cmd_valid),
    .o_cmd_drive(o_cmd_drive),
    .o_cmd_func(o_cmd_func),
    .o_irq(o_irq)
  );

  peer_port_model #(.NUM_DRIVES(4)) peer_u (
    .i_clk(i_clk),
    .i_claim(claim),
    .i_port_hold(o_port_hold),
    .o_peer_busy(peer_busy),
    .o_drive_present(present)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared bus cycles and comparison; each returns 1 ns into the cycle
  // after the strobe, where read data stand.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus_wr(input logic [1:0] d, input logic [2:0] r,
                        input logic [15:0] data);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= {d, r};
    i_wdata <= data;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic bus_rd(input logic [1:0] d, input logic [2:0] r);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= {d, r};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // No neutral state: drive 0 reads as peer held until a write seizes it.
  task automatic t_seize_by_write();
    bus_rd(2'd0, REG_CTL);
    chk(o_rdata, 16'h0000);
    bus_wr(2'd0, REG_GEN, 16'h1234);
    chk({12'h000, o_port_hold}, 16'h0001);
    bus_rd(2'd0, REG_CTL);
    chk(o_rdata & 16'h0800, 16'h0800);
    bus_rd(2'd0, REG_TYPE);
    chk(o_rdata & 16'h0800, 16'h0000);
    bus_rd(2'd0, REG_ATTN);
    chk(o_rdata & 16'h000f, 16'h0001);
  endtask

  // A function written to a seized drive is issued two cycles later.
  task automatic t_command();
    bus_wr(2'd0, REG_CTL, 16'h0047);
    wait_cyc(1);
    chk({15'h0000, o_cmd_valid}, 16'h0001);
    chk({11'h000, o_cmd_func}, 16'h0003);
    chk({14'h0000, o_cmd_drive}, 16'h0000);
    chk({15'h0000, o_irq}, 16'h0001);
  endtask

  // Release shows unseized at once while the port is still held.
  task automatic t_release();
    bus_wr(2'd0, REG_CTL, 16'h004b);
    bus_rd(2'd0, REG_CTL);
    chk(o_rdata, 16'h0000);
    chk({15'h0000, o_port_hold[0]}, 16'h0001);
    wait_cyc(REL + 4);
    chk({15'h0000, o_port_hold[0]}, 16'h0000);
    // Drive 0 is left alone until the stall test reads it after the clear.
  endtask

  // A request against a peer-held drive is remembered and acted on.
  task automatic t_deferred();
    int n;
    claim[1] <= 1'b1;
    wait_cyc(6);
    bus_wr(2'd1, REG_GEN, 16'h5555);
    wait_cyc(2);
    chk({15'h0000, o_port_hold[1]}, 16'h0000);
    bus_rd(2'd1, REG_GEN);
    chk(o_rdata, 16'h0000);
    claim[1] <= 1'b0;
    n = 0;
    while (o_port_hold[1] !== 1'b1 && n < 10) begin
      wait_cyc(1);
      n = n + 1;
    end
    chk({15'h0000, o_port_hold[1]}, 16'h0001);
    bus_rd(2'd0, REG_ATTN);
    chk(o_rdata & 16'h0002, 16'h0002);
  endtask

  // Attention write seizes; no refresh means release, attention stays.
  task automatic t_timeout();
    bus_wr(2'd0, REG_ATTN, 16'h0004);
    chk({15'h0000, o_port_hold[2]}, 16'h0001);
    wait_cyc(SEC - 10);
    chk({15'h0000, o_port_hold[2]}, 16'h0001);
    wait_cyc(SEC + REL);
    chk({15'h0000, o_port_hold[2]}, 16'h0000);
    bus_rd(2'd0, REG_ATTN);
    chk(o_rdata & 16'h0004, 16'h0004);
    chk({15'h0000, o_irq}, 16'h0001);
  endtask

  // Control reads and a data transfer both keep the timer from firing.
  task automatic t_refresh();
    bus_wr(2'd3, REG_GEN, 16'h0001);
    repeat (4) begin
      wait_cyc(SEC - 20);
      bus_rd(2'd3, REG_CTL);
    end
    chk({15'h0000, o_port_hold[3]}, 16'h0001);
    @(posedge i_clk);
    i_xfer_busy <= 1'b1;
    bus_wr(2'd2, REG_GEN, 16'h0002);
    wait_cyc(2 * SEC);
    chk({15'h0000, o_port_hold[3]}, 16'h0001);
    chk({15'h0000, o_port_hold[2]}, 16'h0000);
    @(posedge i_clk);
    i_xfer_busy <= 1'b0;
    wait_cyc(SEC + REL + 5);
    chk({15'h0000, o_port_hold[3]}, 16'h0000);
  endtask

  // Single-port mode: drives stay visible and commands wait for the peer.
  task automatic t_single();
    int n;
    @(posedge i_clk);
    i_dual_port_switch <= 1'b0;
    claim[1] <= 1'b1;
    wait_cyc(6);
    bus_rd(2'd1, REG_CTL);
    chk(o_rdata & 16'h0800, 16'h0800);
    bus_rd(2'd1, REG_TYPE);
    chk(o_rdata & 16'h0800, 16'h0800);
    bus_rd(2'd1, REG_STAT);
    chk(o_rdata & 16'h0200, 16'h0200);
    bus_wr(2'd1, REG_CTL, 16'h0007);
    n = 0;
    repeat (20) begin
      wait_cyc(1);
      if (o_cmd_valid !== 1'b0) begin
        n = n + 1;
      end
    end
    chk(16'(n), 16'h0000);
    claim[1] <= 1'b0;
    n = 0;
    while (o_cmd_valid !== 1'b1 && n < 10) begin
      wait_cyc(1);
      n = n + 1;
    end
    chk({15'h0000, o_cmd_valid}, 16'h0001);
    chk({14'h0000, o_cmd_drive}, 16'h0001);
    chk({11'h000, o_cmd_func}, 16'h0003);
  endtask

  // A mid-run clear without dual access: drive 0 reads zero while stalled, then reads again.
  task automatic t_stall();
    @(posedge i_clk);
    i_srst <= 1'b1;
    i_dual_access_switch <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    wait_cyc(5);
    bus_rd(2'd0, REG_CTL);
    chk(o_rdata, 16'h0000);
    wait_cyc(SEC);
    bus_rd(2'd0, REG_CTL);
    chk(o_rdata & 16'h0800, 16'h0800);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence after a 20 cycle reset and the switch synchronisers.
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    wait_cyc(5);
    t_seize_by_write();
    t_command();
    t_release();
    t_deferred();
    t_timeout();
    t_refresh();
    t_single();
    t_stall();
    end_sim();
  end
endmodule
